// ### verilog/pll_synth_control.sv
// Purpose: Configuration, reference and main registers with standby control
// Assumes: Serial pins asynchronous, two-flop synchronised here
// Notes: Serial rate must stay well below clk/4
//
// Functional notes
// R1: 8-clock access loads configuration only
// R2: Polarity inverts A, swaps B outputs
// R3: Select bit picks detector A or B
// R4: Lock detect enabled else held low
// R5: Standby tri-states A, forces B, stops counters
// R6: Standby lock detect follows enable bit
// R7: Standby keeps all register contents
// R8: Static-low reference mode isolates input in standby
// R9: Recovery step one: counters on, pulses blocked
// R10: First comparison pulse jam-loads, then releases
// R11: Small-step table 70 to 100 percent
// R12: Large-step table 25 to 100 percent
// R13: Both current bits give full current
// R14: Port mode drives output A from config
// R15: Port mode uses small-step table
// R16: Config bit 0 sets open-drain output B
// R17: Output A defaults to serial data out
// R18: 16-clock access: mode now, ratio buffered
// R19: Bare enable pulse moves ratio buffer
// R20: 24-clock access loads main, moves buffer
// R21: Power-up reference ratio is eight
// R22: Modulus low divides 65, high 64
// R23: Reference mode encodings as listed
// R24: Lock detect is AND of B outputs
`timescale 1ns/1ps
`include "pll_ctrl_map.svh"
module pll_synth_control
  import pll_ctrl_pkg::*;
#(
  parameter int MAIN_WIDTH = 24,
  parameter int RATIO_WIDTH = 13
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial port
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic serial_enable_strobe_n,
  // Loop timing from counters and detector core
  input wire logic reference_pulse,
  input wire logic comparison_pulse,
  input wire logic countEnd,
  input wire logic rawLeads,
  input wire logic rawLags,
  input wire logic modulusSelect,
  // Detector outputs
  output logic single_ended_detector_out,
  output logic detectorAOe,
  output logic detectorAHigh,
  output logic detectorRefOut_n,
  output logic detectorCmpOut_n,
  output logic lock_detect_out,
  // General-purpose outputs
  output logic outputA,
  output logic outputBOut,
  output logic outputBOe,
  // Counter and analog controls
  output logic countersRun,
  output logic referenceJamLoad,
  output logic detectorInit,
  output logic pulsesToDetectors,
  output logic biasEnable,
  output logic feedbackResistorOn,
  output logic referenceInputOn,
  output logic [2:0] referenceMode,
  output logic [RATIO_WIDTH-1:0] activeRatio,
  output logic [MAIN_WIDTH-1:0] main_counter_word,
  output logic [6:0] pumpPercent,
  output logic divideBy64
);
  logic [1:0] sclkSync_q;
  logic [1:0] sdatSync_q;
  logic [1:0] enbSync_q;
  logic [MAIN_WIDTH-1:0] shiftWord;
  logic [5:0] bitCount;
  logic accessDone;
  logic loadPulse;
  logic shiftOut;
  logic [7:0] config_byte_q;
  logic [RATIO_WIDTH-1:0] ratioBuffer_q;
  logic ratioPending_q;
  power_state_type state_q;
  logic standby;
  logic portMode;
  logic gated;
  logic leadsPol;
  logic lagsPol;
  logic [6:0] pumpPercent_d;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclkSync_q <= 2'h0;
      sdatSync_q <= 2'h0;
      enbSync_q <= 2'h3;
    end else begin
      sclkSync_q <= {sclkSync_q[0], serialClock};
      sdatSync_q <= {sdatSync_q[0], serialData};
      enbSync_q <= {enbSync_q[0], serial_enable_strobe_n};
    end
  end

  serial_capture #(
    .WIDTH(MAIN_WIDTH)
  ) capture (
    .clk(clk),
    .sys_rst(sys_rst),
    .serialClock(sclkSync_q[1]),
    .serialData(sdatSync_q[1]),
    .enableLevel(enbSync_q[1]),
    .shiftWord(shiftWord),
    .bitCount(bitCount),
    .accessDone(accessDone),
    .loadPulse(loadPulse),
    .shiftOut(shiftOut)
  );

  // ----------------------------------------
  // Register loads
  // ----------------------------------------
  // Other lengths are ignored; standby never touches these registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      config_byte_q <= `CFG_RESET;
    end else if (accessDone && bitCount == `LEN_CONFIG) begin
      config_byte_q <= shiftWord[7:0]; // R1 R7
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      main_counter_word <= `MAIN_RESET;
    end else if (accessDone && bitCount == `LEN_MAIN) begin
      main_counter_word <= shiftWord; // R20 R7
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      referenceMode <= `REF_MODE_DIV8; // R21
      ratioBuffer_q <= `REF_RATIO_RESET;
    end else if (accessDone && bitCount == `LEN_REF) begin
      referenceMode <= shiftWord[`REF_MODE_HI:`REF_MODE_LO]; // R18 R23
      ratioBuffer_q <= shiftWord[`REF_RATIO_HI:0]; // R18
    end
  end

  // Second buffer waits for the end of the running count cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ratioPending_q <= 1'b0;
      activeRatio <= `REF_RATIO_RESET;
    end else begin
      if (loadPulse || (accessDone && bitCount == `LEN_MAIN)) begin
        ratioPending_q <= 1'b1; // R19 R20
      end else if (ratioPending_q && countEnd) begin
        ratioPending_q <= 1'b0;
      end
      if (ratioPending_q && countEnd) begin
        activeRatio <= ratioBuffer_q; // R19
      end
    end
  end

  // ----------------------------------------
  // Standby and orderly recovery
  // ----------------------------------------
  // Recovery waits for a comparison pulse so the counters restart in step;
  // releasing on the standby edge alone would give a random first phase
  // error and a longer relock. If no comparison pulse ever arrives the
  // detectors stay blocked, which is the safe side.
  // Re-entering standby while waiting simply returns to standby.
  assign standby = config_byte_q[`CFG_STANDBY_REQUEST];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= RUN;
    end else begin
      unique case (state_q)
        RUN: if (standby) state_q <= STANDBY; // R5
        STANDBY: if (!standby) state_q <= WAIT_COMPARE; // R9
        WAIT_COMPARE: begin
          if (standby) begin
            state_q <= STANDBY;
          end else if (comparison_pulse) begin
            state_q <= RUN; // R10
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      countersRun <= 1'b1;
      biasEnable <= 1'b1;
      referenceJamLoad <= 1'b0;
      detectorInit <= 1'b0;
      pulsesToDetectors <= 1'b1;
    end else begin
      countersRun <= !standby; // R5 R9
      biasEnable <= !standby; // R5 R9
      referenceJamLoad <= state_q == WAIT_COMPARE && comparison_pulse && !standby; // R10
      detectorInit <= state_q == WAIT_COMPARE && comparison_pulse && !standby; // R10
      pulsesToDetectors <= state_q == RUN && !standby; // R9 R10
    end
  end

  // Static-low reference output assumed to be the disabled-output mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      feedbackResistorOn <= 1'b1;
      referenceInputOn <= 1'b1;
    end else begin
      feedbackResistorOn <= !(standby && referenceMode == `REF_MODE_OFF); // R8
      referenceInputOn <= !(standby && referenceMode == `REF_MODE_OFF); // R8
    end
  end

  // ----------------------------------------
  // Detector and lock outputs
  // ----------------------------------------
  assign gated = pulsesToDetectors;
  assign leadsPol = config_byte_q[`CFG_POL] ? rawLags : rawLeads; // R2
  assign lagsPol = config_byte_q[`CFG_POL] ? rawLeads : rawLags; // R2

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      single_ended_detector_out <= 1'b0;
      detectorAOe <= 1'b0;
      detectorAHigh <= 1'b0;
      detectorRefOut_n <= 1'b1;
      detectorCmpOut_n <= 1'b1;
      lock_detect_out <= 1'b0;
    end else begin
      // Tri-state when B selected or in standby
      detectorAOe <= config_byte_q[`CFG_SEL] && !standby && gated
        && (leadsPol || lagsPol); // R3 R5
      detectorAHigh <= lagsPol; // R2
      single_ended_detector_out <= lagsPol;
      if (config_byte_q[`CFG_SEL] || standby || !gated) begin
        detectorRefOut_n <= 1'b1; // R3 R5
        detectorCmpOut_n <= 1'b1;
      end else begin
        detectorRefOut_n <= !lagsPol;
        detectorCmpOut_n <= !leadsPol;
      end
      if (!config_byte_q[`CFG_LDE]) begin
        lock_detect_out <= 1'b0; // R4 R6
      end else if (standby) begin
        lock_detect_out <= 1'b1; // R6
      end else begin
        lock_detect_out <= !(gated && (leadsPol || lagsPol)); // R24
      end
    end
  end

  // ----------------------------------------
  // General outputs and pump current
  // ----------------------------------------
  assign portMode = main_counter_word[`MAIN_OUTA_HI:`MAIN_OUTA_LO] == `OUTA_PORT;

  always_comb begin
    if (config_byte_q[`CFG_IHI] && config_byte_q[`CFG_ILO]) begin
      pumpPercent_d = `PCT_FULL; // R13
    end else if (config_byte_q[`CFG_PORT] && !portMode) begin
      pumpPercent_d = 7'((config_byte_q[3:2] + 2'h1) * `PCT_STEP25); // R12
    end else begin
      pumpPercent_d = 7'(`PCT_STEP10_BASE + config_byte_q[3:2] * `PCT_STEP10); // R11 R15
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pumpPercent <= `PCT_STEP10_BASE;
      outputA <= 1'b0;
      outputBOut <= 1'b0;
      outputBOe <= 1'b1;
      divideBy64 <= 1'b0;
    end else begin
      pumpPercent <= pumpPercent_d;
      // Other non-port modes are outside this block; show data out
      outputA <= portMode ? config_byte_q[`CFG_PORT] : shiftOut; // R14 R17
      outputBOut <= 1'b0;
      outputBOe <= !config_byte_q[`CFG_OUTB]; // R16
      divideBy64 <= modulusSelect; // R22
    end
  end
endmodule : pll_synth_control

// ### verilog/pll_ctrl_map.svh
// Purpose: Register layout, reset values and codes for the synthesizer control
// Assumes: Included by the design files only
// Notes: Definitions only
`ifndef PLL_CTRL_MAP_SVH
`define PLL_CTRL_MAP_SVH

// ----------------------------------------
// Access lengths in serial clocks
// ----------------------------------------
`define LEN_CONFIG 6'h08
`define LEN_REF 6'h10
`define LEN_MAIN 6'h18

// ----------------------------------------
// Configuration bit positions
// ----------------------------------------
`define CFG_POL 7
`define CFG_SEL 6
`define CFG_LDE 5
`define CFG_STANDBY_REQUEST 4
`define CFG_IHI 3
`define CFG_ILO 2
`define CFG_PORT 1
`define CFG_OUTB 0
`define CFG_RESET 8'h00

// ----------------------------------------
// Reference word fields
// ----------------------------------------
`define REF_MODE_HI 15
`define REF_MODE_LO 13
`define REF_RATIO_HI 12
`define REF_MODE_STOP 3'h0
`define REF_MODE_XTAL 3'h1
`define REF_MODE_OFF 3'h2
`define REF_MODE_DIV1 3'h3
`define REF_MODE_DIV16 3'h7
`define REF_MODE_DIV8 3'h6
`define REF_RATIO_RESET 13'h0000

// ----------------------------------------
// Main word output A mode field
// ----------------------------------------
`define MAIN_OUTA_HI 23
`define MAIN_OUTA_LO 22
`define OUTA_DATAOUT 2'h0
`define OUTA_PORT 2'h3
`define MAIN_RESET 24'h000000

// ----------------------------------------
// Charge pump current in percent
// ----------------------------------------
`define PCT_FULL 7'h64
`define PCT_STEP10_BASE 7'h46
`define PCT_STEP10 7'h0a
`define PCT_STEP25 7'h19

`endif

// ### verilog/pll_ctrl_pkg.sv
// Purpose: Types shared by the synthesizer control
// Assumes: Constants live in pll_ctrl_map.svh
// Notes: Types only
package pll_ctrl_pkg;
  typedef enum {
    RUN,
    STANDBY,
    WAIT_COMPARE
  } power_state_type;
endpackage : pll_ctrl_pkg

// ### verilog/serial_capture.sv
// Purpose: Serial shift and access length counting
// Assumes: All inputs already synchronised to clk
// Notes: Reports length at the enable rising edge
`timescale 1ns/1ps
`include "pll_ctrl_map.svh"
module serial_capture #(
  parameter int WIDTH = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Synchronised serial pins
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic enableLevel,
  // Captured access
  output logic [WIDTH-1:0] shiftWord,
  output logic [5:0] bitCount,
  output logic accessDone,
  output logic loadPulse,
  output logic shiftOut
);
  logic clkPrev_q;
  logic enbPrev_q;
  logic sawClock_q;

  // ----------------------------------------
  // Shift on rising serial clock while enabled low
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkPrev_q <= 1'b0;
      enbPrev_q <= 1'b1;
      shiftWord <= '0;
      bitCount <= 6'h00;
      sawClock_q <= 1'b0;
      shiftOut <= 1'b0;
    end else begin
      clkPrev_q <= serialClock;
      enbPrev_q <= enableLevel;
      if (!enableLevel && serialClock && !clkPrev_q) begin
        shiftWord <= {shiftWord[WIDTH-2:0], serialData};
        shiftOut <= shiftWord[WIDTH-1];
        if (bitCount != 6'h3f) begin
          bitCount <= bitCount + 6'h01;
        end
        sawClock_q <= 1'b1;
      end else if (!enableLevel && enbPrev_q) begin
        // Cleared at access start so the length survives the ending edge
        bitCount <= 6'h00;
        sawClock_q <= 1'b0;
      end
    end
  end

  // Rising enable ends an access; no clocks at all, with the serial clock low, means a load pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accessDone <= 1'b0;
      loadPulse <= 1'b0;
    end else begin
      accessDone <= enableLevel && !enbPrev_q && sawClock_q;
      loadPulse <= enableLevel && !enbPrev_q && !sawClock_q && !serialClock;
    end
  end
endmodule : serial_capture

// ### tb/pll_host_model.sv
// Purpose: Serial host model for the synthesizer control
// Assumes: Tasks are entered at a falling clock edge
// Notes: Clock idles low, data idles inverted
`timescale 1ns/1ps
module pll_host_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic serialClock,
  output logic serialData,
  output logic serial_enable_strobe_n
);
  initial begin
    serialClock = 1'b0;
    serialData = 1'b1;
    serial_enable_strobe_n = 1'b1;
  end
  // MSB first; 4-clock half periods keep above the 3-clock floor
  task automatic send(input int n, input logic [23:0] w);
    serial_enable_strobe_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serialData = w[i];
      repeat (4) @(negedge clk);
      serialClock = 1'b1;
      repeat (4) @(negedge clk);
      serialClock = 1'b0;
    end
    repeat (4) @(negedge clk);
    serial_enable_strobe_n = 1'b1;
    serialData = ~serialData;
    repeat (8) @(negedge clk);
  endtask : send
  // Bare enable pulse with the clock held low
  task automatic move();
    serial_enable_strobe_n = 1'b0;
    repeat (4) @(negedge clk);
    serial_enable_strobe_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask : move
endmodule : pll_host_model

// ### tb/pll_synth_control_chk.sv
// Purpose: Port checker for the synthesizer control
// Assumes: One clock, synchronous reset
// Notes: Bound to every instance
`timescale 1ns/1ps
module pll_synth_control_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Watched ports
  input wire logic comparison_pulse,
  input wire logic modulusSelect,
  input wire logic detectorAOe,
  input wire logic detectorRefOut_n,
  input wire logic detectorCmpOut_n,
  input wire logic outputBOut,
  input wire logic countersRun,
  input wire logic referenceJamLoad,
  input wire logic detectorInit,
  input wire logic pulsesToDetectors,
  input wire logic [6:0] pumpPercent,
  input wire logic divideBy64
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_standby_a_off: assert property (!countersRun |-> !detectorAOe)
    else $error("detector A driven in standby");
  a_standby_b_rest: assert property (!countersRun |-> detectorRefOut_n && detectorCmpOut_n)
    else $error("detector B not at rest in standby");
  a_jam_with_init: assert property (referenceJamLoad |-> detectorInit)
    else $error("jam load without detector init");
  a_jam_after_cmp: assert property (referenceJamLoad |-> $past(comparison_pulse))
    else $error("jam load without comparison pulse");
  a_release_after_jam: assert property (referenceJamLoad |-> ##[0:1] pulsesToDetectors)
    else $error("pulses not released after jam load");
  a_recovery_blocked: assert property ($rose(countersRun) |-> !pulsesToDetectors)
    else $error("pulses passed at recovery start");
  a_pump_legal: assert property (pumpPercent inside {7'h46, 7'h50, 7'h5a, 7'h64,
    7'h19, 7'h32, 7'h4b})
    else $error("pump current outside both tables");
  a_modulus_follow: assert property (divideBy64 == $past(modulusSelect))
    else $error("modulus output does not follow select");
  a_outb_low_only: assert property (outputBOut == 1'b0)
    else $error("output B driven high");
endmodule : pll_synth_control_chk
bind pll_synth_control pll_synth_control_chk chk_u (.clk, .sys_rst, .comparison_pulse,
  .modulusSelect, .detectorAOe, .detectorRefOut_n, .detectorCmpOut_n, .outputBOut,
  .countersRun, .referenceJamLoad, .detectorInit, .pulsesToDetectors, .pumpPercent,
  .divideBy64);

// ### tb/pll_synth_config_standby_control_bench.sv
// Purpose: Bench for the synthesizer control
// Assumes: Host model drives the serial port
// Notes: Inputs change at falling edges
`timescale 1ns/1ps
module pll_synth_config_standby_control_bench;
  import pll_ctrl_pkg::*;
  logic clk, sys_rst, serialClock, serialData, serial_enable_strobe_n;
  logic reference_pulse, comparison_pulse, countEnd, rawLeads, rawLags, modulusSelect;
  logic single_ended_detector_out, detectorAOe, detectorAHigh, detectorRefOut_n;
  logic detectorCmpOut_n, lock_detect_out, outputA, outputBOut, outputBOe, countersRun;
  logic referenceJamLoad, detectorInit, pulsesToDetectors, biasEnable, divideBy64;
  logic feedbackResistorOn, referenceInputOn, seen;
  logic [2:0] referenceMode;
  logic [12:0] activeRatio;
  logic [23:0] main_counter_word;
  logic [6:0] pumpPercent, expPump;
  logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  pll_synth_control dut_u (.clk, .sys_rst, .serialClock, .serialData,
    .serial_enable_strobe_n, .reference_pulse, .comparison_pulse, .countEnd, .rawLeads,
    .rawLags, .modulusSelect, .single_ended_detector_out, .detectorAOe, .detectorAHigh,
    .detectorRefOut_n, .detectorCmpOut_n, .lock_detect_out, .outputA, .outputBOut,
    .outputBOe, .countersRun, .referenceJamLoad, .detectorInit, .pulsesToDetectors,
    .biasEnable, .feedbackResistorOn, .referenceInputOn, .referenceMode, .activeRatio,
    .main_counter_word, .pumpPercent, .divideBy64);
  pll_host_model host_u (.clk, .serialClock, .serialData, .serial_enable_strobe_n);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string what, input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic test_done();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done
  task automatic cfg(input logic [7:0] v);
    host_u.send(8, {16'h0000, v});
  endtask : cfg
  task automatic ref16(input logic [2:0] m, input logic [12:0] r);
    host_u.send(16, {8'h00, m, r});
  endtask : ref16
  // Ceiling well above the few thousand cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    sys_rst = 1'b1;
    reference_pulse = 1'b0;
    comparison_pulse = 1'b0;
    countEnd = 1'b0;
    rawLeads = 1'b0;
    rawLags = 1'b1;
    modulusSelect = 1'b0;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    chk("aOe", detectorAOe, 1'b0);
    chk("lock", lock_detect_out, 1'b0);
    chk("outBOe", outputBOe, 1'b1);
    chk("mode", referenceMode, 3'h6);
    chk("outA", outputA, 1'b0);
    for (int k = 0; k < 8; k++) begin
      cfg({4'h4, k[1:0], k[2], k[0]});
      expPump = k[2] ? 7'h19 * (7'(k[1:0]) + 7'h01) : 7'h46 + 7'h0a * 7'(k[1:0]);
      chk("pump", pumpPercent, expPump);
      chk("outBOe", outputBOe, !k[0]);
      chk("aOe", detectorAOe, 1'b1);
      chk("bRest", {detectorRefOut_n, detectorCmpOut_n}, 2'b11);
      chk("lock", lock_detect_out, 1'b0);
    end
    seen = single_ended_detector_out;
    cfg(8'hc0);
    chk("pol", single_ended_detector_out, !seen);
    modulusSelect = 1'b1;
    repeat (2) @(negedge clk);
    chk("div64", divideBy64, 1'b1);
    ref16(3'h3, 13'h0123);
    chk("ratio", activeRatio, 13'h0000);
    chk("pump", pumpPercent, 7'h46);
    host_u.move();
    countEnd = 1'b1;
    @(negedge clk);
    countEnd = 1'b0;
    repeat (3) @(negedge clk);
    chk("ratio", activeRatio, 13'h0123);
    for (int k = 0; k < 5; k++) begin
      ref16(modes[k], 13'h0456);
      chk("mode", referenceMode, modes[k]);
    end
    host_u.send(24, 24'h000abc);
    chk("main", main_counter_word, 24'h000abc);
    chk("ratio", activeRatio, 13'h0123);
    countEnd = 1'b1;
    @(negedge clk);
    countEnd = 1'b0;
    repeat (3) @(negedge clk);
    chk("ratio", activeRatio, 13'h0456);
    cfg(8'h4c);
    chk("main", main_counter_word, 24'h000abc);
    chk("pump", pumpPercent, 7'h64);
    host_u.send(24, 24'hc00abc);
    cfg(8'h42);
    chk("outA", outputA, 1'b1);
    chk("pump", pumpPercent, 7'h46);
    ref16(3'h2, 13'h0456);
    cfg(8'h72);
    chk("run", {countersRun, biasEnable, detectorAOe}, 3'h0);
    chk("lock", lock_detect_out, 1'b1);
    chk("outA", outputA, 1'b1);
    chk("reference_input", {referenceInputOn, feedbackResistorOn}, 2'b00);
    chk("main", main_counter_word, 24'hc00abc);
    chk("mode", referenceMode, 3'h2);
    cfg(8'h62);
    chk("run", {countersRun, biasEnable, pulsesToDetectors}, 3'h6);
    chk("reference_input", {referenceInputOn, feedbackResistorOn}, 2'b11);
    comparison_pulse = 1'b1;
    @(negedge clk);
    comparison_pulse = 1'b0;
    repeat (3) @(negedge clk);
    chk("pass", pulsesToDetectors, 1'b1);
    ref16(3'h1, 13'h0456);
    cfg(8'h50);
    chk("lock", lock_detect_out, 1'b0);
    chk("reference_input", referenceInputOn, 1'b1);
    chk("outBOe", outputBOe, 1'b1);
    test_done();
  end
endmodule : pll_synth_config_standby_control_bench
